// ---- core_model.sv ----
// Behavioural processor core: acknowledges requests and returns from service
`timescale 1ns/1ps

module core_model
  import irq_ctrl_pkg::*;
#(
  parameter int SERVICE = 40
) (
  input  wire logic                           clock_i,
  input  wire logic                           arst_n_i,
  input  wire logic                           irq_take_i,
  input  wire logic                           pc_load_i,
  input  wire logic [irq_ctrl_pkg::PC_W-1:0]  pc_vector_i,
  input  wire logic                           slow_i,
  output logic                                irq_ack_o,
  output logic                                return_o,
  output logic      [irq_ctrl_pkg::PC_W-1:0]  vec_seen_o,
  output int                                  n_take_o
);
  logic [7:0] wait_ff;
  logic [7:0] svc_ff;

  // ==========================================================================
  // Acknowledge, late when slow so the request must stand meanwhile
  // ==========================================================================
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_ff   <= 8'h00;
      irq_ack_o <= 1'b0;
    end else begin
      irq_ack_o <= 1'b0;
      if (irq_take_i && !irq_ack_o && svc_ff == 8'h00) begin
        if (slow_i && wait_ff < 8'h05) wait_ff <= wait_ff + 8'h01;
        else begin
          irq_ack_o <= 1'b1;
          wait_ff   <= 8'h00;
        end
      end
    end
  end

  // Service routine length, then return; software clears flags meanwhile
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      svc_ff     <= 8'h00;
      return_o   <= 1'b0;
      vec_seen_o <= '0;
      n_take_o   <= 0;
    end else begin
      return_o <= (svc_ff == 8'h01);
      if (pc_load_i) begin
        svc_ff     <= 8'(SERVICE);
        vec_seen_o <= pc_vector_i;
        n_take_o   <= n_take_o + 1;
      end else if (svc_ff != 8'h00) svc_ff <= svc_ff - 8'h01;
    end
  end
endmodule : core_model

// ---- irq_ctrl_pkg.sv ----
// Constants, register map and carrier types of the microcontroller interrupt controller
package irq_ctrl_pkg;

  // ==========================================================================
  // Bus geometry
  // ==========================================================================
  localparam int            ADDR_W        = 10;
  localparam int            BUS_W         = 32;
  localparam int            PC_W          = 12;

  // ==========================================================================
  // Register indexes (byte address is four times the index)
  // ==========================================================================
  localparam logic [7:0]    IDX_EDGE      = 8'hbf;
  localparam logic [7:0]    IDX_PEND      = 8'hc8;
  localparam logic [7:0]    IDX_EN        = 8'hc9;
  localparam logic [7:0]    IDX_STACK_POINTER_GLOBAL_ENABLE      = 8'hdf;
  localparam logic [7:0]    IDX_EVT_STAT  = 8'he0;
  localparam logic [7:0]    IDX_EVT_MASK  = 8'he1;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int            BIT_EXT       = 0;
  localparam int            BIT_T0        = 4;
  localparam int            BIT_TC        = 5;
  localparam int            BIT_GIE       = 7;
  localparam int            EDGE_LO       = 3;
  localparam int            EDGE_HI       = 4;

  // Writable bits of each register; all others read as zero
  localparam logic [7:0]    SRC_MASK      = 8'h31;
  localparam logic [7:0]    EDGE_MASK     = 8'h18;
  localparam logic [7:0]    STACK_POINTER_GLOBAL_ENABLE_MASK     = 8'h83;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]    EDGE_RST      = 8'h10;
  localparam logic [7:0]    PEND_RST      = 8'h00;
  localparam logic [7:0]    EN_RST        = 8'h00;
  localparam logic [7:0]    STACK_POINTER_GLOBAL_ENABLE_RST      = 8'h03;
  localparam logic [7:0]    EVT_RST       = 8'h00;

  // ==========================================================================
  // Edge select codes, vector and context layout
  // ==========================================================================
  localparam logic [1:0]    EDGE_RESERVED = 2'b00;
  localparam logic [1:0]    EDGE_RISE     = 2'b01;
  localparam logic [1:0]    EDGE_FALL     = 2'b10;
  localparam logic [1:0]    EDGE_BOTH     = 2'b11;
  localparam logic [PC_W-1:0] IRQ_VECTOR  = 12'h008;
  // Program flag bits kept by save and restore; timeout and powerdown flags excluded
  localparam logic [7:0]    FLAGS_KEEP    = 8'h3f;

  typedef struct packed {
    logic [7:0] working_reg;
    logic [7:0] program_flags;
  } ctx_s;

endpackage : irq_ctrl_pkg

// ---- mcu_interrupt_controller.sv ----
// Interrupt controller with register slave, edge detect, vectoring and context buffer
`timescale 1ns/1ps

module mcu_interrupt_controller (
  input  wire logic                             clock_i,
  input  wire logic                             arst_n_i,
  input  wire logic [irq_ctrl_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                             avs_read_i,
  input  wire logic                             avs_write_i,
  input  wire logic [irq_ctrl_pkg::BUS_W-1:0]   avs_writedata_i,
  input  wire logic [3:0]                       avs_byteenable_i,
  output logic      [irq_ctrl_pkg::BUS_W-1:0]   avs_readdata_o,
  output logic                                  avs_waitrequest_o,
  input  wire logic                             timer_zero_ovf_i,
  input  wire logic                             timer_counter_ovf_i,
  input  wire logic                             ext_line_pin_i,
  input  wire logic                             powerdown_i,
  input  wire logic                             irq_ack_i,
  input  wire logic                             return_from_irq_i,
  output logic                                  irq_take_o,
  output logic                                  pc_load_o,
  output logic      [irq_ctrl_pkg::PC_W-1:0]    pc_vector_o,
  output logic                                  stack_push_o,
  output logic      [1:0]                       stack_level_o,
  output logic                                  wake_o,
  input  wire logic                             ctx_save_i,
  input  wire logic                             ctx_restore_i,
  input  wire irq_ctrl_pkg::ctx_s               ctx_i,
  output irq_ctrl_pkg::ctx_s                    ctx_o,
  output logic                                  ctx_valid_o,
  output logic                                  irq_o
);
  import irq_ctrl_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // True when the pin transition matches the selected edge code
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    case (sel)
      EDGE_RISE: hit = rise;
      EDGE_FALL: hit = fall;
      EDGE_BOTH: hit = rise | fall;
      default:   hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit

  // Source event vector in register layout, one bit per source
  function automatic logic [7:0] src_vec(input logic ext, input logic t0, input logic tc);
    logic [7:0] v;
    v          = 8'h00;
    v[BIT_EXT] = ext;
    v[BIT_T0]  = t0;
    v[BIT_TC]  = tc;
    return v;
  endfunction : src_vec

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;

  bus_state_e        bus_ff;
  logic [7:0]        edge_ff;
  logic [7:0]        pend_ff;
  logic [7:0]        en_ff;
  logic              gie_ff;
  logic [1:0]        level_ff;
  logic [7:0]        evt_stat_ff;
  logic [7:0]        evt_mask_ff;
  logic              pin_prev_ff;
  logic              wake_latch_ff;
  logic [BUS_W-1:0]  rdata_ff;
  logic              irq_take_ff;
  logic              pc_load_ff;
  logic              push_ff;
  logic              wake_ff;
  ctx_s              ctx_buf_ff;
  logic              ctx_valid_ff;
  logic              irq_ff;

  logic [7:0]        idx;
  logic              aligned;
  logic              wr_commit;
  logic              wr_lane;
  logic [7:0]        wdata;
  logic              rise;
  logic              fall;
  logic              ext_evt;
  logic [7:0]        events;
  logic              take;

  // ==========================================================================
  // Avalon slave: one wait cycle, then answer
  // ==========================================================================
  assign idx       = avs_address_i[ADDR_W-1:2];
  assign aligned   = (avs_address_i[1:0] == 2'b00);
  assign wdata     = avs_writedata_i[7:0];
  assign wr_lane   = avs_byteenable_i[0] & aligned;
  assign wr_commit = avs_write_i & (bus_ff == BUS_ANSWER);

  // Waitrequest stays high except in the answer cycle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_ff <= BUS_IDLE;
    end else begin
      case (bus_ff)
        BUS_IDLE:   if (avs_read_i | avs_write_i) bus_ff <= BUS_ANSWER;
        BUS_ANSWER: bus_ff <= BUS_IDLE;
        default:    bus_ff <= BUS_IDLE;
      endcase
    end
  end

  // Read data captured on the first cycle so it stands in the answer cycle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= '0;
    end else if (avs_read_i && bus_ff == BUS_IDLE) begin
      rdata_ff <= '0;
      if (!aligned) begin
        rdata_ff <= '0;
      end else if (idx == IDX_EDGE) begin
        rdata_ff[7:0] <= edge_ff;
      end else if (idx == IDX_PEND) begin
        rdata_ff[7:0] <= pend_ff;
      end else if (idx == IDX_EN) begin
        rdata_ff[7:0] <= en_ff;
      end else if (idx == IDX_STACK_POINTER_GLOBAL_ENABLE) begin
        rdata_ff[7:0] <= {gie_ff, 5'b00000, level_ff};
      end else if (idx == IDX_EVT_STAT) begin
        rdata_ff[7:0] <= evt_stat_ff;
      end else if (idx == IDX_EVT_MASK) begin
        rdata_ff[7:0] <= evt_mask_ff;
      end
    end
  end

  assign avs_readdata_o    = rdata_ff;
  assign avs_waitrequest_o = (bus_ff != BUS_ANSWER);

  // ==========================================================================
  // Edge detection and source events
  // ==========================================================================
  // Pin is taken as synchronous; only the previous level is kept
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_prev_ff <= 1'b1;
    end else begin
      pin_prev_ff <= ext_line_pin_i;
    end
  end

  assign rise    = ext_line_pin_i & ~pin_prev_ff;
  assign fall    = ~ext_line_pin_i & pin_prev_ff;
  assign ext_evt = edge_hit(edge_ff[EDGE_HI:EDGE_LO], rise, fall);
  assign events  = src_vec(ext_evt, timer_zero_ovf_i, timer_counter_ovf_i);

  // Edge select register, reserved code stored as written
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      edge_ff <= EDGE_RST;
    end else if (wr_commit && wr_lane && idx == IDX_EDGE) begin
      edge_ff <= wdata & EDGE_MASK;
    end
  end

  // Pending flags: source set beats a software clear in the same cycle
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_ff <= PEND_RST;
    end else if (wr_commit && wr_lane && idx == IDX_PEND) begin
      pend_ff <= (wdata | events) & SRC_MASK;
    end else begin
      pend_ff <= pend_ff | events;
    end
  end

  // Enable bits, plain storage
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_ff <= EN_RST;
    end else if (wr_commit && wr_lane && idx == IDX_EN) begin
      en_ff <= wdata & SRC_MASK;
    end
  end

  // ==========================================================================
  // Wake-up from powerdown
  // ==========================================================================
  // Any pin change wakes; only a matching edge is latched for service
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_ff       <= 1'b0;
      wake_latch_ff <= 1'b0;
    end else begin
      wake_ff <= powerdown_i & (rise | fall);
      if (powerdown_i && ext_evt) begin
        wake_latch_ff <= 1'b1;
      end else if (take) begin
        wake_latch_ff <= 1'b0;
      end
    end
  end

  assign wake_o = wake_ff;

  // ==========================================================================
  // Global enable, stack level and vectoring
  // ==========================================================================
  // Ack is honoured only while a request is shown; no service during powerdown
  assign take = irq_ack_i & irq_take_ff;

  // Hardware entry and exit win over a software write to the same bit
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gie_ff   <= 1'b0;
      level_ff <= STACK_POINTER_GLOBAL_ENABLE_RST[1:0];
    end else begin
      if (take) begin
        gie_ff <= 1'b0;
      end else if (return_from_irq_i) begin
        gie_ff <= 1'b1;
      end else if (wr_commit && wr_lane && idx == IDX_STACK_POINTER_GLOBAL_ENABLE) begin
        gie_ff <= wdata[BIT_GIE];
      end
      // Stack grows downward; wrap is the core's concern
      if (take) begin
        level_ff <= level_ff - 2'd1;
      end else if (return_from_irq_i) begin
        level_ff <= level_ff + 2'd1;
      end else if (wr_commit && wr_lane && idx == IDX_STACK_POINTER_GLOBAL_ENABLE) begin
        level_ff <= wdata[1:0];
      end
    end
  end

  // Request and the entry pulses toward the core
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_take_ff <= 1'b0;
      pc_load_ff  <= 1'b0;
      push_ff     <= 1'b0;
    end else begin
      irq_take_ff <= gie_ff & ~take & ~powerdown_i & (|(pend_ff & en_ff));
      pc_load_ff  <= take;
      push_ff     <= take;
    end
  end

  assign irq_take_o    = irq_take_ff;
  assign pc_load_o     = pc_load_ff;
  assign pc_vector_o   = IRQ_VECTOR;
  assign stack_push_o  = push_ff;
  assign stack_level_o = level_ff;

  // ==========================================================================
  // One-level context buffer
  // ==========================================================================
  // A second save overwrites the first; there is no nesting
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctx_buf_ff   <= '0;
      ctx_valid_ff <= 1'b0;
    end else begin
      if (ctx_save_i) begin
        ctx_buf_ff.working_reg   <= ctx_i.working_reg;
        ctx_buf_ff.program_flags <= ctx_i.program_flags & FLAGS_KEEP;
      end
      ctx_valid_ff <= ctx_restore_i;
    end
  end

  assign ctx_o       = ctx_buf_ff;
  assign ctx_valid_o = ctx_valid_ff;

  // ==========================================================================
  // Event status, mask and interrupt line
  // ==========================================================================
  // Write one to clear; a new event in the same cycle keeps its bit
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      evt_stat_ff <= EVT_RST;
      evt_mask_ff <= EVT_RST;
    end else begin
      if (wr_commit && wr_lane && idx == IDX_EVT_STAT) begin
        evt_stat_ff <= (evt_stat_ff & ~wdata) | events;
      end else begin
        evt_stat_ff <= evt_stat_ff | events;
      end
      if (wr_commit && wr_lane && idx == IDX_EVT_MASK) begin
        evt_mask_ff <= wdata & SRC_MASK;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(evt_stat_ff & evt_mask_ff);
    end
  end

  assign irq_o = irq_ff;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence entry_s;
    irq_ack_i && irq_take_o;
  endsequence

  sequence vector_s;
    pc_load_o && stack_push_o && (pc_vector_o == 12'h008);
  endsequence

  gie_clear_a: assert property (entry_s |=> !gie_ff)
    else $error("global enable not cleared on entry");
  gie_set_a: assert property (return_from_irq_i && !take |=> gie_ff)
    else $error("global enable not restored on return");
  vector_load_a: assert property (entry_s |=> vector_s ##1 !pc_load_o)
    else $error("vector load not a single pulse to 8");
  stack_push_a: assert property (entry_s |=> stack_level_o == $past(stack_level_o) - 2'd1)
    else $error("stack level not pushed");
  pend_sticky_a: assert property (pend_ff[BIT_T0] && !(wr_commit && idx == IDX_PEND)
                                  |=> pend_ff[BIT_T0])
    else $error("pending flag dropped without software clear");
  t0_set_a: assert property (timer_zero_ovf_i |=> pend_ff[BIT_T0])
    else $error("timer zero flag not set");
  tc_set_a: assert property (timer_counter_ovf_i |=> pend_ff[BIT_TC])
    else $error("timer-counter flag not set");
  ext_set_a: assert property (ext_evt |=> pend_ff[BIT_EXT])
    else $error("external flag not set");
  gie_gate_a: assert property (!gie_ff |=> !irq_take_o)
    else $error("request raised with global enable off");
  req_raise_a: assert property (gie_ff && !take && !powerdown_i && (|(pend_ff & en_ff))
                                |=> irq_take_o)
    else $error("request not raised for enabled pending source");
  wake_latch_a: assert property (powerdown_i && ext_evt |=> wake_latch_ff && pend_ff[BIT_EXT])
    else $error("wake edge not latched");
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
                                 |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle after request");

endmodule : mcu_interrupt_controller

// ---- mcu_interrupt_controller_tb.sv ----
// Self-checking bench for the interrupt controller with a core model
`timescale 1ns/1ps

module mcu_interrupt_controller_tb;
  import irq_ctrl_pkg::*;
  logic        clk, arst_n, rd_en, wr_en, wait_o, t0, tc, pin, pwd;
  logic        ack, ret, take, pcl, push, wake, sv, rs, cval, irq, slow;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic [11:0] vec, vseen;
  logic [1:0]  lvl;
  ctx_s        ctx, cout;
  int          n_mismatch, cmp_count, seed, n_take, n_wake, cyc, n0;
  logic [7:0]  v;
  logic [15:0] cv;

  mcu_interrupt_controller mcu_interrupt_controller_inst (.clock_i(clk), .arst_n_i(arst_n),
    .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
    .timer_zero_ovf_i(t0), .timer_counter_ovf_i(tc), .ext_line_pin_i(pin), .powerdown_i(pwd),
    .irq_ack_i(ack), .return_from_irq_i(ret), .irq_take_o(take), .pc_load_o(pcl),
    .pc_vector_o(vec), .stack_push_o(push), .stack_level_o(lvl), .wake_o(wake),
    .ctx_save_i(sv), .ctx_restore_i(rs), .ctx_i(ctx), .ctx_o(cout), .ctx_valid_o(cval),
    .irq_o(irq));

  core_model #(.SERVICE(40)) core_model_inst (.clock_i(clk), .arst_n_i(arst_n),
    .irq_take_i(take), .pc_load_i(pcl), .pc_vector_i(vec), .slow_i(slow), .irq_ack_o(ack),
    .return_o(ret), .vec_seen_o(vseen), .n_take_o(n_take));

  // ==========================================================================
  // Clock, cycle ceiling and wake pulse count
  // ==========================================================================
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (wake === 1'b1) n_wake++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Avalon access: hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    addr  <= {idx, 2'b00};
    rd_en <= !w;
    wr_en <= w;
    wdata <= {24'h0, d};
    // No local limit: a hung answer is ended by the cycle ceiling only
    do begin
      @(posedge clk);
    end while (wait_o !== 1'b0);
    q = rdata[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(nm, {8'h00, e}, {8'h00, q});
  endtask : rd_chk

  // One-cycle pulse on an event or context strobe
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: t0 <= 1'b1;
      1: tc <= 1'b1;
      2: sv <= 1'b1;
      default: rs <= 1'b1;
    endcase
    @(posedge clk);
    {t0, tc, sv, rs} <= 4'h0;
  endtask : ev

  task automatic set_pin(input logic l);
    @(posedge clk);
    pin <= l;
    repeat (3) @(posedge clk);
  endtask : set_pin

  task automatic wait_take(input int n);
    int t;
    t = 0;
    while (n_take == n && t < 100) begin
      @(posedge clk);
      t++;
    end
    // A take that never comes counts against the run
    if (t >= 100) n_mismatch++;
  endtask : wait_take

  // Expected external flag for a code and a pin transition
  function automatic logic fires(input logic [1:0] c, input logic o, input logic n);
    return (o != n) && (c == EDGE_BOTH || (c == EDGE_RISE && n) || (c == EDGE_FALL && !n));
  endfunction : fires

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = '0;
    wdata = '0;
    be = 4'hf;
    t0 = 1'b0;
    tc = 1'b0;
    pin = 1'b1;
    pwd = 1'b0;
    sv = 1'b0;
    rs = 1'b0;
    ctx = '0;
    slow = 1'b0;
    seed = 72912;
    n_mismatch = 0;
    cmp_count = 0;
    n_wake = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk("edge_select", IDX_EDGE, EDGE_RST);
    rd_chk("pending", IDX_PEND, PEND_RST);
    rd_chk("enable", IDX_EN, EN_RST);
    rd_chk("stack_pointer", IDX_STACK_POINTER_GLOBAL_ENABLE, STACK_POINTER_GLOBAL_ENABLE_RST);
    rd_chk("unmapped", 8'hd0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(IDX_EN, v);
      rd_chk("enable", IDX_EN, v & SRC_MASK);
    end
    be <= 4'h0;
    wr(IDX_EN, 8'hff);
    be <= 4'hf;
    rd_chk("enable masked write", IDX_EN, v & SRC_MASK);
    wr(IDX_EN, 8'h00);
    ev(0);
    ev(1);
    rd_chk("timer flags", IDX_PEND, 8'h30);
    chk("take disabled", 16'h0, {15'h0, take});
    wr(IDX_PEND, 8'h00);
    rd_chk("pending cleared", IDX_PEND, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_EDGE, 8'(c << 3));
      rd_chk("edge code", IDX_EDGE, 8'(c << 3));
      set_pin(1'b0);
      rd_chk("fall flag", IDX_PEND, {7'h0, fires(2'(c), 1'b1, 1'b0)});
      wr(IDX_PEND, 8'h00);
      set_pin(1'b1);
      rd_chk("rise flag", IDX_PEND, {7'h0, fires(2'(c), 1'b0, 1'b1)});
      wr(IDX_PEND, 8'h00);
    end
    wr(IDX_EDGE, {3'h0, EDGE_FALL, 3'h0});
    wr(IDX_EN, SRC_MASK);
    wr(IDX_STACK_POINTER_GLOBAL_ENABLE, 8'h83);
    for (int k = 0; k < 3; k++) begin
      slow <= k[0];
      n0 = n_take;
      if (k == 2) set_pin(1'b0);
      else ev(k);
      wait_take(n0);
      chk("vector", {4'h0, IRQ_VECTOR}, {4'h0, vseen});
      rd_chk("in service", IDX_STACK_POINTER_GLOBAL_ENABLE, 8'h02);
      chk("stack level port", 16'h0002, {14'h0, lvl});
      wr(IDX_PEND, 8'h00);
      repeat (50) @(posedge clk);
      rd_chk("after return", IDX_STACK_POINTER_GLOBAL_ENABLE, 8'h83);
      chk("one take", 16'(n0 + 1), 16'(n_take));
      if (k == 2) set_pin(1'b1);
    end
    wr(IDX_STACK_POINTER_GLOBAL_ENABLE, 8'h03);
    n0 = n_take;
    ev(0);
    repeat (6) @(posedge clk);
    chk("no take without global", 16'(n0), 16'(n_take));
    wr(IDX_PEND, 8'h00);
    wr(IDX_EVT_MASK, 8'h00);
    wr(IDX_EVT_STAT, 8'h31);
    ev(1);
    repeat (3) @(posedge clk);
    chk("irq masked", 16'h0, {15'h0, irq});
    wr(IDX_EVT_MASK, 8'h20);
    repeat (3) @(posedge clk);
    chk("irq unmasked", 16'h1, {15'h0, irq});
    wr(IDX_EVT_STAT, 8'h20);
    repeat (3) @(posedge clk);
    chk("irq cleared", 16'h0, {15'h0, irq});
    wr(IDX_PEND, 8'h00);
    for (int i = 0; i < 3; i++) begin
      cv = 16'($random(seed));
      @(posedge clk);
      ctx <= cv;
      ev(2);
      ev(3);
      @(posedge clk);
      chk("context valid", 16'h1, {15'h0, cval});
      chk("context", {cv[15:8], cv[7:0] & FLAGS_KEEP}, cout);
    end
    wr(IDX_STACK_POINTER_GLOBAL_ENABLE, 8'h83);
    @(posedge clk);
    pwd <= 1'b1;
    n0 = n_take;
    v = 8'(n_wake);
    set_pin(1'b0);
    chk("wake pulse", 16'(v + 1), 16'(n_wake));
    rd_chk("latched edge", IDX_PEND, 8'h01);
    chk("held in powerdown", 16'(n0), 16'(n_take));
    pwd <= 1'b0;
    wait_take(n0);
    chk("served after wake", 16'(n0 + 1), 16'(n_take));
    wr(IDX_PEND, 8'h00);
    repeat (50) @(posedge clk);
    summarize();
  end
endmodule : mcu_interrupt_controller_tb
